/* inc/ssa_pkg.sv */
package ssa_pkg;

    // ----------------------------------------------------------------
    // Host port offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_SELECT = 8'h00;
    localparam logic [7:0] OFS_INIT   = 8'h04;
    localparam logic [7:0] OFS_CLEAR  = 8'h08;
    localparam logic [7:0] OFS_FLAGS  = 8'h0C;
    localparam logic [7:0] OFS_DATA   = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;
    localparam logic [7:0] OFS_MODE   = 8'h18;
    localparam logic [7:0] OFS_TX_SYN = 8'h1C;
    localparam logic [7:0] OFS_RX_SYN = 8'h20;
    localparam logic [7:0] OFS_MASK   = 8'h24;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int FLG_DTR      = 0;
    localparam int FLG_RTS      = 1;
    localparam int FLG_BRK      = 2;
    localparam int MODE_LEN_LO  = 0;
    localparam int MODE_PAR_EN  = 2;
    localparam int MODE_PAR_ODD = 3;
    localparam int MODE_GATE    = 4;
    localparam int ST_RX_AVAIL  = 0;
    localparam int ST_TX_EMPTY  = 1;
    localparam int ST_ERR       = 2;
    localparam int ST_CD        = 3;
    localparam int ST_DSR       = 4;
    localparam int ST_CTS       = 5;
    localparam int ST_SELECTED  = 6;
    localparam int MASK_TX      = 1;
    localparam int MASK_RX      = 2;

    // ----------------------------------------------------------------
    // Reset values and fixed counts
    // ----------------------------------------------------------------
    localparam logic [7:0] SEL_ADDR_RST = 8'hF0;
    localparam logic [7:0] MODE_RST     = 8'h03;
    localparam logic [7:0] SYN_RST      = 8'h16;
    localparam logic [7:0] MASK_RST     = 8'h00;
    localparam logic [3:0] CHAR_MIN     = 4'h5;
    localparam logic [3:0] FRAME_MAX    = 4'h9;

    // Receiver states
    typedef enum logic {
        RX_HUNT = 1'b0,
        RX_DATA = 1'b1
    } ssa_rx_state_type;

endpackage

/* logic/ssa_sync2.sv */
`timescale 1ns/1ns
module ssa_sync2 #(
    parameter int WIDTH = 5
) (
    // Clock and reset
    input  wire logic             ref_clk,
    input  wire logic             rst_b,
    // Pins in, synchronised out
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta;

    // Two flops per pin; the first is read by the second only
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            meta     <= '0;
            sync_out <= '0;
        end else begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end

endmodule

/* logic/ssa_top.sv */
`timescale 1ns/1ns
module ssa_top #(
    parameter logic [7:0] SEL_ADDR = ssa_pkg::SEL_ADDR_RST
) (
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rst_b,
    // Host register port
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    // Serial line
    input  wire logic       bit_clk,
    input  wire logic       rxd,
    output logic            txd,
    // Modem handshake
    output logic            dtr,
    output logic            rts,
    output logic            brk,
    input  wire logic       cd,
    input  wire logic       dsr,
    input  wire logic       cts,
    // Request levels to the host
    output logic            rx_int_req,
    output logic            tx_int_req
);

    // ----------------------------------------------------------------
    // Pin synchronisation and bit clock edges
    // ----------------------------------------------------------------
    logic             bclk_s;
    logic             rxd_s;
    logic             cd_s;
    logic             dsr_s;
    logic             cts_s;
    logic             bclk_q;
    logic             bit_rise;
    logic             bit_fall;

    ssa_sync2 #(.WIDTH(5)) u_sync (
        .ref_clk  (ref_clk),
        .rst_b    (rst_b),
        .async_in ({bit_clk, rxd, cd, dsr, cts}),
        .sync_out ({bclk_s, rxd_s, cd_s, dsr_s, cts_s})
    );

    // Previous bit clock level for edge detection
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            bclk_q <= 1'b0;
        end else begin
            bclk_q <= bclk_s;
        end
    end

    assign bit_rise = bclk_s && !bclk_q;
    assign bit_fall = !bclk_s && bclk_q;

    // ----------------------------------------------------------------
    // Command decode
    // ----------------------------------------------------------------
    logic             selected;
    logic             wr_sel;
    logic             wr_init;
    logic             wr_clear;
    logic             wr_flags;
    logic             wr_data;
    logic             rd_data;
    logic             tx_empty;

    assign wr_sel   = reg_wr && (reg_addr == ssa_pkg::OFS_SELECT);
    assign wr_init  = reg_wr && (reg_addr == ssa_pkg::OFS_INIT);
    assign wr_clear = reg_wr && selected && (reg_addr == ssa_pkg::OFS_CLEAR);
    assign wr_flags = reg_wr && selected && (reg_addr == ssa_pkg::OFS_FLAGS);
    assign wr_data  = reg_wr && selected && tx_empty && (reg_addr == ssa_pkg::OFS_DATA);
    assign rd_data  = reg_rd && selected && (reg_addr == ssa_pkg::OFS_DATA);

    // Selection latch; a select for another device deselects us
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            selected <= 1'b0;
        end else if (wr_init) begin
            selected <= 1'b0;
        end else if (wr_sel) begin
            selected <= (reg_wdata == SEL_ADDR);
        end
    end

    // ----------------------------------------------------------------
    // Configuration
    // ----------------------------------------------------------------
    logic [7:0]       mode;
    logic [7:0]       tx_syn;
    logic [7:0]       rx_syn;
    logic [7:0]       int_mask;

    // Mode and SYN survive initialise so software need not reload them
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            mode   <= ssa_pkg::MODE_RST;
            tx_syn <= ssa_pkg::SYN_RST;
            rx_syn <= ssa_pkg::SYN_RST;
        end else if (reg_wr && selected) begin
            if (reg_addr == ssa_pkg::OFS_MODE) begin
                mode <= reg_wdata;
            end
            if (reg_addr == ssa_pkg::OFS_TX_SYN) begin
                tx_syn <= reg_wdata;
            end
            if (reg_addr == ssa_pkg::OFS_RX_SYN) begin
                rx_syn <= reg_wdata;
            end
        end
    end

    // Request mask, closed by initialise
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            int_mask <= ssa_pkg::MASK_RST;
        end else if (wr_init) begin
            int_mask <= ssa_pkg::MASK_RST;
        end else if (reg_wr && selected && reg_addr == ssa_pkg::OFS_MASK) begin
            int_mask <= reg_wdata;
        end
    end

    // Character geometry
    logic [1:0]       len_code;
    logic             par_en;
    logic [3:0]       data_bits;
    logic [3:0]       frame_bits;
    logic [7:0]       char_mask;

    assign len_code   = mode[ssa_pkg::MODE_LEN_LO +: 2];
    assign par_en     = mode[ssa_pkg::MODE_PAR_EN];
    assign data_bits  = ssa_pkg::CHAR_MIN + {2'b00, len_code};
    assign frame_bits = data_bits + {3'b000, par_en};
    assign char_mask  = 8'hFF >> (2'd3 - len_code);

    // Parity bit for a character: even makes the ones count even
    function automatic logic par_of(input logic [7:0] ch, input logic odd);
        par_of = (^ch) ^ odd;
    endfunction

    // ----------------------------------------------------------------
    // Modem control outputs
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            dtr <= 1'b0;
            rts <= 1'b0;
            brk <= 1'b0;
        end else if (wr_init || wr_clear) begin
            dtr <= 1'b0;
            rts <= 1'b0;
            brk <= 1'b0;
        end else if (wr_flags) begin
            dtr <= reg_wdata[ssa_pkg::FLG_DTR];
            rts <= reg_wdata[ssa_pkg::FLG_RTS];
            brk <= reg_wdata[ssa_pkg::FLG_BRK];
        end
    end

    // ----------------------------------------------------------------
    // Transmitter
    // ----------------------------------------------------------------
    logic [7:0]       tx_hold;
    logic [8:0]       tx_shift;
    logic [3:0]       tx_left;
    logic             tx_data_fr;
    logic             tx_bit;
    logic             tx_pend;
    logic             tx_done;
    logic             idle_ok;
    logic [7:0]       tx_ch;
    logic [8:0]       tx_frame;

    assign tx_pend = !tx_empty && !tx_data_fr;
    // done when the last bit has had its full period
    assign tx_done = bit_fall && (tx_left == 4'h0) && tx_data_fr;
    assign idle_ok = !mode[ssa_pkg::MODE_GATE] || (rts && cts_s);

    // Next frame: data when pending, else idle SYN
    always_comb begin
        tx_ch    = (tx_pend ? tx_hold : tx_syn) & char_mask;
        tx_frame = {1'b0, tx_ch};
        if (par_en) begin
            tx_frame[data_bits] = par_of(tx_ch, mode[ssa_pkg::MODE_PAR_ODD]);
        end
    end

    // Holding register
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            tx_hold <= 8'h00;
        end else if (wr_data) begin
            tx_hold <= reg_wdata;
        end
    end

    // Transmitter-empty flag; writes are refused while clear, so no clash
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            tx_empty <= 1'b1;
        end else if (wr_init || tx_done) begin
            tx_empty <= 1'b1;
        end else if (wr_data) begin
            tx_empty <= 1'b0;
        end
    end

    // Shifter, advanced on the falling bit clock edge, LSB first
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            tx_shift   <= 9'h000;
            tx_left    <= 4'h0;
            tx_data_fr <= 1'b0;
            tx_bit     <= 1'b1;
        end else if (wr_init) begin
            tx_left    <= 4'h0;
            tx_data_fr <= 1'b0;
            tx_bit     <= 1'b1;
        end else if (bit_fall) begin
            if (tx_left != 4'h0) begin
                tx_bit   <= tx_shift[0];
                tx_shift <= {1'b0, tx_shift[8:1]};
                tx_left  <= tx_left - 4'h1;
            end else if (tx_pend || idle_ok) begin
                tx_bit     <= tx_frame[0];
                tx_shift   <= {1'b0, tx_frame[8:1]};
                tx_left    <= frame_bits - 4'h1;
                tx_data_fr <= tx_pend;
            end else begin
                tx_bit     <= 1'b1;
                tx_data_fr <= 1'b0;
            end
        end
    end

    // Break forces the line to space
    assign txd = tx_bit && !brk;

    // ----------------------------------------------------------------
    // Receiver
    // ----------------------------------------------------------------
    ssa_pkg::ssa_rx_state_type rx_state;
    logic [7:0]       rx_win;
    logic [7:0]       next_win;
    logic [8:0]       rx_sh;
    logic [8:0]       next_sh;
    logic [8:0]       rx_aligned;
    logic [3:0]       rx_cnt;
    logic             rx_done;
    logic             rx_pbad;
    logic [7:0]       rx_ch;
    logic [7:0]       rx_data;
    logic             rx_avail;
    logic             err;

    assign next_win   = {rxd_s, rx_win[7:1]};
    assign next_sh    = {rxd_s, rx_sh[8:1]};
    assign rx_aligned = next_sh >> (ssa_pkg::FRAME_MAX - frame_bits);
    assign rx_ch      = rx_aligned[7:0] & char_mask;
    assign rx_done    = bit_rise && (rx_state == ssa_pkg::RX_DATA)
                        && (rx_cnt == frame_bits - 4'h1);
    assign rx_pbad    = par_en
                        && (rx_aligned[data_bits] != par_of(rx_ch,
                                                            mode[ssa_pkg::MODE_PAR_ODD]));

    // Hunt window and character assembly on the rising bit clock edge
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rx_state <= ssa_pkg::RX_HUNT;
            rx_win   <= 8'h00;
            rx_sh    <= 9'h000;
            rx_cnt   <= 4'h0;
        end else if (wr_init || wr_clear) begin
            rx_state <= ssa_pkg::RX_HUNT;
            rx_cnt   <= 4'h0;
        end else if (bit_rise) begin
            rx_win <= next_win;
            rx_sh  <= next_sh;
            unique case (rx_state)
                ssa_pkg::RX_HUNT: begin
                    if (next_win == rx_syn) begin
                        rx_state <= ssa_pkg::RX_DATA;
                        rx_cnt   <= 4'h0;
                    end
                end
                ssa_pkg::RX_DATA: begin
                    rx_cnt <= rx_done ? 4'h0 : rx_cnt + 4'h1;
                end
            endcase
        end
    end

    // Received character buffer
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rx_data <= 8'h00;
        end else if (rx_done) begin
            rx_data <= rx_ch;
        end
    end

    // Receive-available: a new character wins over any clear
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rx_avail <= 1'b0;
        end else if (rx_done) begin
            rx_avail <= 1'b1;
        end else if (wr_init || wr_clear || rd_data) begin
            rx_avail <= 1'b0;
        end
    end

    // Error flag: parity or overrun sets, good character or clear resets
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            err <= 1'b0;
        end else if (rx_done && (rx_avail || rx_pbad)) begin
            err <= 1'b1;
        end else if (wr_init || wr_clear) begin
            err <= 1'b0;
        end else if (rx_done) begin
            err <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Host requests and read port
    // ----------------------------------------------------------------
    logic [7:0]       status;

    assign rx_int_req = selected && int_mask[ssa_pkg::MASK_RX] && rx_avail;
    assign tx_int_req = selected && int_mask[ssa_pkg::MASK_TX] && tx_empty;

    always_comb begin
        status                       = 8'h00;
        status[ssa_pkg::ST_RX_AVAIL] = rx_avail;
        status[ssa_pkg::ST_TX_EMPTY] = tx_empty;
        status[ssa_pkg::ST_ERR]      = err;
        status[ssa_pkg::ST_CD]       = cd_s;
        status[ssa_pkg::ST_DSR]      = dsr_s;
        status[ssa_pkg::ST_CTS]      = cts_s;
        status[ssa_pkg::ST_SELECTED] = selected;
    end

    // Read data stands one cycle; deselected or unmapped reads give zero
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd && selected) begin
            unique case (reg_addr)
                ssa_pkg::OFS_STATUS: reg_rdata <= status;
                ssa_pkg::OFS_DATA:   reg_rdata <= rx_data;
                ssa_pkg::OFS_FLAGS:  reg_rdata <= {5'h00, brk, rts, dtr};
                ssa_pkg::OFS_MODE:   reg_rdata <= mode;
                ssa_pkg::OFS_TX_SYN: reg_rdata <= tx_syn;
                ssa_pkg::OFS_RX_SYN: reg_rdata <= rx_syn;
                ssa_pkg::OFS_MASK:   reg_rdata <= int_mask;
                default:             reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    sel_mismatch_a: assert property (
        wr_sel && !wr_init && reg_wdata != SEL_ADDR |=> !selected)
        else $error("select with wrong address took effect");

    init_desel_a: assert property (
        wr_init |=> !selected && !tx_int_req && !rx_int_req)
        else $error("initialise left the adapter selected");

    flags_follow_a: assert property (
        wr_flags && !wr_init |=> {brk, rts, dtr} == $past(reg_wdata[2:0]))
        else $error("output flags do not follow the command");

    modem_clear_a: assert property (
        wr_init || wr_clear |=> !dtr && !rts && !brk)
        else $error("modem outputs not cleared");

    tx_empty_a: assert property (
        wr_data && !wr_init |=> !tx_empty ##1 !tx_empty)
        else $error("transmit write did not clear empty flag");

    tx_refill_a: assert property (
        tx_done |=> tx_empty && !tx_data_fr)
        else $error("empty flag not set after shift-out");

    rx_syn_first_a: assert property (
        $rose(rx_avail) |-> $past(rx_state) == ssa_pkg::RX_DATA)
        else $error("character delivered without SYN");

    rx_clear_a: assert property (
        (wr_init || wr_clear || rd_data) && !rx_done |=> !rx_avail)
        else $error("receive-available not cleared");

    overrun_a: assert property (
        rx_done && rx_avail |=> err && rx_avail)
        else $error("overrun not flagged");

    err_clear_a: assert property (
        (wr_init || wr_clear) && !rx_done |=> !err)
        else $error("error flag not cleared");

    gated_idle_a: assert property (
        bit_fall && tx_left == 4'h0 && !tx_pend && !idle_ok && !wr_init
        |=> tx_left == 4'h0 && tx_bit)
        else $error("idle SYN sent while handshake inactive");

    tx_req_full_a: assert property (
        !tx_empty |-> !tx_int_req)
        else $error("transmit request while buffer full");

endmodule

/* tb/ssa_peer.sv */
`timescale 1ns/1ns
// Peer station: a plug that loops line and handshakes back
module ssa_peer (
    // Adapter side
    input  wire logic txd,
    input  wire logic dtr,
    input  wire logic rts,
    input  wire logic brk,
    output logic      bit_clk,
    output logic      rxd,
    output logic      cd,
    output logic      dsr,
    output logic      cts,
    // Bench control
    input  wire logic loop_on,
    input  wire logic invert
);
    initial begin
        bit_clk = 1'b0;
        forever begin
            #62 bit_clk = 1'b1;
            #63 bit_clk = 1'b0;
        end
    end
    // Unplugged line rests at mark, never at a stale bit
    assign rxd = loop_on ? (txd ^ invert) : 1'b1;
    // Control outputs come back as status
    assign cd  = dtr;
    assign dsr = brk;
    assign cts = rts;
endmodule

/* tb/testbench.sv */
`timescale 1ns/1ns
module testbench;
    localparam logic [7:0] RXA = 8'h01, TXE = 8'h02, ERR = 8'h04, MOD = 8'h38;
    logic       ref_clk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic       loop_on = 1'b0, invert = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, d;
    logic [7:0] reg_rdata;
    logic       bit_clk, rxd, txd, dtr, rts, brk, cd, dsr, cts, rx_int_req, tx_int_req;
    int         num_errors = 0, checks = 0, cyc = 0;
    logic [7:0] mds [5] = '{8'h00, 8'h05, 8'h0E, 8'h03, 8'h0F};
    logic [7:0] sys [5] = '{8'h16, 8'h1A, 8'hB4, 8'h96, 8'h96};
    logic [7:0] chs [5] = '{8'h0B, 8'h25, 8'h55, 8'hA5, 8'h3C};

    ssa_top dut_u (.ref_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .bit_clk, .rxd, .txd, .dtr, .rts, .brk, .cd, .dsr, .cts, .rx_int_req, .tx_int_req);
    ssa_peer peer_u (.txd, .dtr, .rts, .brk, .bit_clk, .rxd, .cd, .dsr, .cts, .loop_on,
        .invert);

    // 250 MHz clock
    initial begin
        forever #2 ref_clk = ~ref_clk;
    end
    // Hang guard, well above the expected run length
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            num_errors = num_errors + 1;
            give_verdict();
        end
    end

    // ----------------------------------------
    // Host port access
    // ----------------------------------------
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
        @(posedge ref_clk);
    endtask
    // Read data stands one cycle only, so sample mid-cycle
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge ref_clk);
        reg_rd   <= 1'b0;
        @(negedge ref_clk);
        v = reg_rdata;
        @(posedge ref_clk);
    endtask
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        checks = checks + 1;
        if (g !== e) begin
            num_errors = num_errors + 1;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic st(input string n, input logic [7:0] m, input logic [7:0] e);
        logic [7:0] s;
        rd(ssa_pkg::OFS_STATUS, s);
        chk(n, e, s & m);
    endtask
    // Bounded poll of status bits
    task automatic wst(input logic [7:0] m);
        logic [7:0] s = 8'h00;
        for (int i = 0; i < 600 && (s & m) !== m; i++) rd(ssa_pkg::OFS_STATUS, s);
    endtask
    task automatic get(output logic [7:0] v);
        wst(RXA);
        rd(ssa_pkg::OFS_DATA, v);
    endtask
    task automatic ints(input string n, input logic [7:0] e);
        @(negedge ref_clk);
        chk(n, e, {6'h00, rx_int_req, tx_int_req});
        @(posedge ref_clk);
    endtask
    // Watch the line for any space bit
    task automatic line(input string n, input logic e);
        logic z = 1'b0;
        repeat (600) @(posedge ref_clk);
        repeat (600) @(negedge ref_clk) z = z | ~txd;
        chk(n, {7'h00, e}, {7'h00, z});
        @(posedge ref_clk);
    endtask
    // Window ends on a frame boundary so the receiver frames like the sender
    task automatic run(input logic [7:0] m, input logic [7:0] s, input logic [7:0] c);
        int          w;
        int          wt;
        logic [7:0]  k;
        logic [7:0]  v;
        logic [17:0] f;
        w  = 5 + int'(m[1:0]);
        wt = w + int'(m[2]);
        k  = 8'hFF >> (8 - w);
        f  = 18'(s & k) | (18'((^(s & k) ^ m[3]) & m[2]) << w);
        f  = (f | (f << wt)) >> (2 * wt - 8);
        wr(ssa_pkg::OFS_MODE, m);
        wr(ssa_pkg::OFS_TX_SYN, s);
        wr(ssa_pkg::OFS_RX_SYN, f[7:0]);
        wr(ssa_pkg::OFS_INIT, 8'h00);
        wr(ssa_pkg::OFS_SELECT, 8'hF0);
        st("first_sel", TXE, TXE);
        get(v);
        chk("rx_syn", s & k, v);
        wr(ssa_pkg::OFS_DATA, c);
        st("tx_busy", TXE, 8'h00);
        for (int i = 0; i < 6 && v === (s & k); i++) get(v);
        chk("rx_char", c & k, v);
        st("good_par", ERR, 8'h00);
        wst(TXE);
        st("tx_done", TXE, TXE);
    endtask
    task automatic give_verdict();
        if (num_errors == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        repeat (16) @(posedge ref_clk);
        rst_b <= 1'b1;
        @(posedge ref_clk);
        st("unselected", 8'hFF, 8'h00);
        wr(ssa_pkg::OFS_SELECT, 8'hF1);
        st("bad_sel", 8'hFF, 8'h00);
        wr(ssa_pkg::OFS_SELECT, 8'hF0);
        st("sel", 8'h42, 8'h42);
        wr(ssa_pkg::OFS_FLAGS, 8'h02);
        rd(ssa_pkg::OFS_FLAGS, d);
        st("rts_only", MOD, 8'h20);
        wr(ssa_pkg::OFS_FLAGS, 8'h07);
        rd(ssa_pkg::OFS_FLAGS, d);
        chk("flags", 8'h07, d);
        st("all_set", MOD, MOD);
        wr(ssa_pkg::OFS_INIT, 8'h00);
        wr(ssa_pkg::OFS_FLAGS, 8'h01);
        wr(ssa_pkg::OFS_SELECT, 8'hF0);
        rd(ssa_pkg::OFS_FLAGS, d);
        chk("init_flags", 8'h00, d);
        st("init_lines", MOD, 8'h00);
        wr(ssa_pkg::OFS_FLAGS, 8'h05);
        wr(ssa_pkg::OFS_CLEAR, 8'h00);
        rd(ssa_pkg::OFS_FLAGS, d);
        chk("clr_flags", 8'h00, d);
        st("clr_lines", MOD, 8'h00);
        wr(ssa_pkg::OFS_RX_SYN, 8'h00);
        loop_on <= 1'b1;
        wr(ssa_pkg::OFS_DATA, 8'hA5);
        wst(RXA);
        st("no_syn", RXA, 8'h00);
        wr(ssa_pkg::OFS_MODE, 8'h13);
        line("gated", 1'b0);
        wr(ssa_pkg::OFS_FLAGS, 8'h02);
        line("ungated", 1'b1);
        foreach (mds[i]) run(mds[i], sys[i], chs[i]);
        invert <= 1'b1;
        get(d);
        get(d);
        st("par_err", ERR, ERR);
        invert <= 1'b0;
        get(d);
        get(d);
        st("err_gone", ERR, 8'h00);
        wst(ERR);
        st("overrun", ERR | RXA, ERR | RXA);
        wr(ssa_pkg::OFS_CLEAR, 8'h00);
        st("clr_err", ERR | RXA, 8'h00);
        wst(ERR);
        wr(ssa_pkg::OFS_INIT, 8'h00);
        wr(ssa_pkg::OFS_SELECT, 8'hF0);
        st("init_err", ERR | RXA, 8'h00);
        get(d);
        st("read_clr", RXA, 8'h00);
        wr(ssa_pkg::OFS_MASK, 8'h02);
        ints("tx_int", 8'h01);
        wr(ssa_pkg::OFS_DATA, 8'h3C);
        ints("tx_full", 8'h00);
        wr(ssa_pkg::OFS_MASK, 8'h04);
        wst(RXA);
        ints("rx_int", 8'h02);
        wr(ssa_pkg::OFS_MASK, 8'h00);
        ints("no_int", 8'h00);
        give_verdict();
    end
endmodule
